// *** hw/swr_pkg.sv ***
// Constants and types shared by the sleep, wake and reset-cause block
package swr_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_CFG = 8'h08;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFF_STATE = 8'h14;
    localparam logic [7:0] OFF_PORT = 8'h18;
    // Cause flag positions in STATUS
    localparam int POS_TIMEOUT_N = 4;
    localparam int POS_POWERDOWN_N = 3;
    localparam int POS_PIN_WAKE = 7;
    // CTRL command bits
    localparam int POS_SLEEP_CMD = 0;
    localparam int POS_WDT_CLEAR = 1;
    // CFG bits
    localparam int POS_WDT_EN = 0;
    localparam int POS_WAKE_CHG_EN = 1;
    localparam int POS_EXT_RESET_MODE = 2;
    localparam logic [2:0] CFG_RESET = 3'h5;
    // Interrupt event bits
    localparam int IRQ_W = 3;
    localparam int POS_EV_WAKE = 0;
    localparam int POS_EV_WDT = 1;
    localparam int POS_EV_EXT = 2;
    localparam logic [IRQ_W-1:0] IRQ_STAT_RESET = 3'h0;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
    // Flag values after power-up
    localparam logic TIMEOUT_N_RESET = 1'b1;
    localparam logic POWERDOWN_N_RESET = 1'b1;
    localparam logic PIN_WAKE_RESET = 1'b0;
    // Port pins
    localparam int IO_W = 6;
    localparam logic [IO_W-1:0] IO_OUT_RESET = 6'h00;
    localparam logic [IO_W-1:0] IO_OE_N_RESET = 6'h3f;
    localparam logic [2:0] PIN_REF_RESET = 3'h0;
    // Timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int WDT_PERIOD_NS = 18000000;
    localparam int DRT_POR_NS = 18000000;
    localparam int DRT_RESET_NS = 300000;
    localparam int WDT_CYCLES = WDT_PERIOD_NS / CLK_PERIOD_NS;
    localparam int DRT_POR_CYCLES = (DRT_POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DRT_RESET_CYCLES = (DRT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 20;
    localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
    // Power states
    typedef enum logic [1:0] {
        PS_RUN = 2'b00,
        PS_SLEEP = 2'b01,
        PS_RESET = 2'b10
    } swr_state_t;
endpackage : swr_pkg

// *** hw/swr_sleep_wake.sv ***
// Sleep, wake-up and reset-cause controller with APB register access
// How it works
// - Watchdog time-out while running clears timeout and pin-wake flags, keeps powerdown.
// - Power-up sets powerdown flag; a sleep command while running clears it unless a watchdog or reset-pin reset wins that cycle.
// - External reset while running clears pin-wake flag, keeps the other two.
// - Pin-change wake leaves pin-wake 1, timeout 1, powerdown 0.
// - Watchdog wake from sleep clears timeout, so all three flags read zero.
// - Flags hold until the next reset or sleep command; a reset pin pulse alone changes neither timeout nor powerdown.
// - Sleep clears watchdog, sets timeout flag, clears powerdown, stops oscillator.
// - During sleep each I/O pin keeps its previous drive: high, low or off.
// - A watchdog reset never drives the external reset pin low.
// - With wake-on-change enabled, a change on pins 0 or 1, or on pin 3 when not the reset input, wakes.
// - Watchdog wakes from sleep only when enabled by configuration.
// - The shared pin acts as reset only when configured as reset input.
// - Pin wake compares against pin state at last port access.
// - A mismatch already present at sleep entry wakes at once.
// - The watchdog is cleared on every wake from sleep.
// - Every wake is carried out as a full device reset.
// - A watchdog time-out starts the reset timer holding the core in reset.
//
// The register addresses and the APB slave port are this design's own decisions.
module swr_sleep_wake #(
    parameter int WDT_CYC = swr_pkg::WDT_CYCLES,
    parameter int DRT_POR_CYC = swr_pkg::DRT_POR_CYCLES,
    parameter int DRT_RST_CYC = swr_pkg::DRT_RESET_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_reset_pin_n_i,
    output logic ext_reset_pin_o,
    output logic ext_reset_pin_oe_n,
    input wire logic port_pin0,
    input wire logic port_pin1,
    input wire logic port_pin3,
    input wire logic [swr_pkg::IO_W-1:0] core_io_out,
    input wire logic [swr_pkg::IO_W-1:0] core_io_oe_n,
    output logic [swr_pkg::IO_W-1:0] io_out,
    output logic [swr_pkg::IO_W-1:0] io_oe_n,
    output logic osc_driver_en,
    output logic core_reset,
    output logic irq
);
    import swr_pkg::*;

    localparam logic [CNT_W-1:0] WDT_LAST = CNT_W'(WDT_CYC - 1);
    localparam logic [CNT_W-1:0] DRT_POR_LOAD = CNT_W'(DRT_POR_CYC - 1);
    localparam logic [CNT_W-1:0] DRT_RST_LOAD = CNT_W'(DRT_RST_CYC - 1);

    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
        addr_is = (a == off);
    endfunction : addr_is

    // Registers
    swr_state_t state_reg, state_next;
    logic timeout_flag_n_reg, timeout_flag_n_next;
    logic powerdown_flag_n_reg, powerdown_flag_n_next;
    logic pin_wake_flag_reg, pin_wake_flag_next;
    logic [CNT_W-1:0] wdt_cnt_reg, wdt_cnt_next;
    logic [CNT_W-1:0] drt_cnt_reg, drt_cnt_next;
    logic [2:0] cfg_reg;
    logic [2:0] pin_ref_reg;
    logic [IRQ_W-1:0] irq_stat_reg, irq_mask_reg;
    logic ext_low_d_reg;
    logic pready_reg, pslverr_reg;
    logic [31:0] prdata_reg;
    logic [IO_W-1:0] io_out_reg, io_oe_n_reg;
    logic osc_en_reg, core_reset_reg, irq_reg;

    // Bus decode
    wire access = psel & penable;
    wire done = access & pready_reg;
    wire wr_done = done & pwrite;
    wire rd_done = done & ~pwrite;
    wire sel_status = addr_is(paddr, OFF_STATUS);
    wire sel_ctrl = addr_is(paddr, OFF_CTRL);
    wire sel_cfg = addr_is(paddr, OFF_CFG);
    wire sel_irq_stat = addr_is(paddr, OFF_IRQ_STAT);
    wire sel_irq_mask = addr_is(paddr, OFF_IRQ_MASK);
    wire sel_state = addr_is(paddr, OFF_STATE);
    wire sel_port = addr_is(paddr, OFF_PORT);
    logic hit;
    logic [31:0] rdata;
    // Pin 3 is a plain watched input unless it serves as the reset pin
    wire [2:0] watched_now = {port_pin3, port_pin1, port_pin0};

    always_comb begin
        hit = 1'b1;
        rdata = 32'h00000000;
        if (sel_status) begin
            rdata[POS_PIN_WAKE] = pin_wake_flag_reg;
            rdata[POS_TIMEOUT_N] = timeout_flag_n_reg;
            rdata[POS_POWERDOWN_N] = powerdown_flag_n_reg;
        end else if (sel_ctrl) begin
            rdata = 32'h00000000;
        end else if (sel_cfg) begin
            rdata[2:0] = cfg_reg;
        end else if (sel_irq_stat) begin
            rdata[IRQ_W-1:0] = irq_stat_reg;
        end else if (sel_irq_mask) begin
            rdata[IRQ_W-1:0] = irq_mask_reg;
        end else if (sel_state) begin
            rdata[1:0] = state_reg;
            rdata[2] = osc_en_reg;
            rdata[3] = core_reset_reg;
            rdata[6:4] = pin_ref_reg;
        end else if (sel_port) begin
            rdata[2:0] = watched_now;
        end else begin
            hit = 1'b0;
        end
    end

    // Configuration view
    wire wdt_en = cfg_reg[POS_WDT_EN];
    wire wake_chg_en = cfg_reg[POS_WAKE_CHG_EN];
    wire ext_mode = cfg_reg[POS_EXT_RESET_MODE];

    // Commands
    wire cmd_wr = wr_done & sel_ctrl & ~pslverr_reg;
    wire sleep_cmd = cmd_wr & pwdata[POS_SLEEP_CMD] & (state_reg == PS_RUN);
    wire wdt_clear_cmd = cmd_wr & pwdata[POS_WDT_CLEAR];
    // Any port access re-arms the change reference
    wire port_access = done & sel_port;

    wire [2:0] watch_mask = {~ext_mode, 2'b11};
    wire ext_low = ext_mode & ~ext_reset_pin_n_i;
    wire ext_fall = ext_low & ~ext_low_d_reg;
    // All detection runs on pclk, which keeps running while the core oscillator is off
    wire wdt_to = wdt_en & (wdt_cnt_reg == WDT_LAST);
    // Level compare, so a stale mismatch wakes straight away
    wire pin_chg = wake_chg_en & (((watched_now ^ pin_ref_reg) & watch_mask) != 3'h0);

    wire asleep = (state_reg == PS_SLEEP);
    wire running = (state_reg == PS_RUN);
    wire wake_ext = asleep & ext_fall;
    wire wake_wdt = asleep & ~ext_fall & wdt_to;
    wire wake_pin = asleep & ~ext_fall & ~wdt_to & pin_chg;
    wire any_wake = wake_ext | wake_wdt | wake_pin;
    wire run_ext = running & ext_fall;
    wire run_wdt = running & ~ext_fall & wdt_to;

    // Power state and reset-cause flags
    always_comb begin
        state_next = state_reg;
        timeout_flag_n_next = timeout_flag_n_reg;
        powerdown_flag_n_next = powerdown_flag_n_reg;
        pin_wake_flag_next = pin_wake_flag_reg;
        drt_cnt_next = drt_cnt_reg;
        case (state_reg)
            PS_RUN: begin
                if (run_ext) begin
                    state_next = PS_RESET;
                    pin_wake_flag_next = 1'b0;
                    drt_cnt_next = DRT_RST_LOAD;
                end else if (run_wdt) begin
                    state_next = PS_RESET;
                    timeout_flag_n_next = 1'b0;
                    pin_wake_flag_next = 1'b0;
                    drt_cnt_next = DRT_RST_LOAD;
                end else if (sleep_cmd) begin
                    state_next = PS_SLEEP;
                    timeout_flag_n_next = 1'b1;
                    powerdown_flag_n_next = 1'b0;
                end
            end
            PS_SLEEP: begin
                if (any_wake) begin
                    state_next = PS_RESET;
                    drt_cnt_next = DRT_RST_LOAD;
                end
                if (wake_ext) begin
                    pin_wake_flag_next = 1'b0;
                end else if (wake_wdt) begin
                    timeout_flag_n_next = 1'b0;
                    pin_wake_flag_next = 1'b0;
                end else if (wake_pin) begin
                    pin_wake_flag_next = 1'b1;
                end
            end
            PS_RESET: begin
                // Timer waits for the reset pin to be released
                if (ext_low) begin
                    drt_cnt_next = DRT_RST_LOAD;
                end else if (drt_cnt_reg == CNT_ZERO) begin
                    state_next = PS_RUN;
                end else begin
                    drt_cnt_next = drt_cnt_reg - CNT_W'(1);
                end
            end
            default: begin
                state_next = PS_RESET;
                drt_cnt_next = DRT_RST_LOAD;
            end
        endcase
    end

    // Watchdog keeps counting in sleep; cleared on sleep, wake and command
    wire wdt_restart = ~wdt_en | wdt_to | sleep_cmd | any_wake | wdt_clear_cmd;
    assign wdt_cnt_next = wdt_restart ? CNT_ZERO : wdt_cnt_reg + CNT_W'(1);

    // Interrupt status: set wins over the read clear
    wire [IRQ_W-1:0] ev;
    assign ev[POS_EV_WAKE] = any_wake;
    assign ev[POS_EV_WDT] = wdt_to;
    assign ev[POS_EV_EXT] = ext_fall;
    wire irq_rd = rd_done & sel_irq_stat;
    wire [IRQ_W-1:0] irq_clr = irq_rd ? prdata_reg[IRQ_W-1:0] : IRQ_STAT_RESET;
    wire [IRQ_W-1:0] irq_stat_next = (irq_stat_reg & ~irq_clr) | ev;

    // I/O drive frozen across sleep
    wire hold_io = (state_next == PS_SLEEP);
    wire [IO_W-1:0] io_out_next = hold_io ? io_out_reg : core_io_out;
    wire [IO_W-1:0] io_oe_n_next = hold_io ? io_oe_n_reg : core_io_oe_n;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= PS_RESET;
            timeout_flag_n_reg <= TIMEOUT_N_RESET;
            powerdown_flag_n_reg <= POWERDOWN_N_RESET;
            pin_wake_flag_reg <= PIN_WAKE_RESET;
            wdt_cnt_reg <= CNT_ZERO;
            drt_cnt_reg <= DRT_POR_LOAD;
            ext_low_d_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            timeout_flag_n_reg <= timeout_flag_n_next;
            powerdown_flag_n_reg <= powerdown_flag_n_next;
            pin_wake_flag_reg <= pin_wake_flag_next;
            wdt_cnt_reg <= wdt_cnt_next;
            drt_cnt_reg <= drt_cnt_next;
            ext_low_d_reg <= ext_low;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= CFG_RESET;
            irq_mask_reg <= IRQ_MASK_RESET;
            irq_stat_reg <= IRQ_STAT_RESET;
            pin_ref_reg <= PIN_REF_RESET;
        end else begin
            if (wr_done && sel_cfg) begin
                cfg_reg <= pwdata[2:0];
            end
            if (wr_done && sel_irq_mask) begin
                irq_mask_reg <= pwdata[IRQ_W-1:0];
            end
            irq_stat_reg <= irq_stat_next;
            if (port_access) begin
                pin_ref_reg <= watched_now;
            end
        end
    end

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else begin
            pready_reg <= access & ~pready_reg;
            pslverr_reg <= access & ~pready_reg & ~hit;
            if (access && !pready_reg) begin
                prdata_reg <= pwrite ? 32'h00000000 : rdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_out_reg <= IO_OUT_RESET;
            io_oe_n_reg <= IO_OE_N_RESET;
            osc_en_reg <= 1'b1;
            core_reset_reg <= 1'b1;
            irq_reg <= 1'b0;
        end else begin
            io_out_reg <= io_out_next;
            io_oe_n_reg <= io_oe_n_next;
            osc_en_reg <= (state_next != PS_SLEEP);
            core_reset_reg <= (state_next == PS_RESET);
            irq_reg <= |(irq_stat_next & irq_mask_reg);
        end
    end

    // The reset pin is input only; an internal reset never pulls it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_reset_pin_o <= 1'b1;
            ext_reset_pin_oe_n <= 1'b1;
        end else begin
            ext_reset_pin_o <= 1'b1;
            ext_reset_pin_oe_n <= 1'b1;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign io_out = io_out_reg;
    assign io_oe_n = io_oe_n_reg;
    assign osc_driver_en = osc_en_reg;
    assign core_reset = core_reset_reg;
    assign irq = irq_reg;
endmodule : swr_sleep_wake

// *** testbench/swr_sleep_wake_monitor.sv ***
// Port-level checker for the sleep, wake and reset-cause block
module swr_sleep_wake_monitor (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    input logic pready,
    input logic pslverr,
    input logic ext_reset_pin_o,
    input logic ext_reset_pin_oe_n,
    input logic [swr_pkg::IO_W-1:0] io_out,
    input logic [swr_pkg::IO_W-1:0] io_oe_n,
    input logic osc_driver_en,
    input logic core_reset
);
    import swr_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_one_wait; psel && $rose(penable) |=> pready; endproperty
    a_one_wait: assert property (p_one_wait) else $error("no answer after one wait");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    property p_pin_free; ext_reset_pin_oe_n && ext_reset_pin_o; endproperty
    a_pin_free: assert property (p_pin_free) else $error("reset pin driven");
    // A reset in the command cycle skips the oscillator drop, so reset also counts
    property p_sleep_osc; psel && penable && pready && pwrite && paddr == OFF_CTRL
        && pwdata[POS_SLEEP_CMD] && !core_reset |-> ##[1:3] (!osc_driver_en || core_reset);
    endproperty
    a_sleep_osc: assert property (p_sleep_osc) else $error("osc on in sleep");
    property p_io_hold; !osc_driver_en && !$past(osc_driver_en)
        |-> $stable(io_out) && $stable(io_oe_n); endproperty
    a_io_hold: assert property (p_io_hold) else $error("io moved in sleep");
    property p_wake_reset; $rose(osc_driver_en) |-> ##[0:1] core_reset; endproperty
    a_wake_reset: assert property (p_wake_reset) else $error("wake without reset");
    property p_reset_hold; $rose(core_reset) |-> core_reset [*8]; endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("reset timer short");
endmodule : swr_sleep_wake_monitor

bind swr_sleep_wake swr_sleep_wake_monitor u_mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .ext_reset_pin_o(ext_reset_pin_o),
    .ext_reset_pin_oe_n(ext_reset_pin_oe_n), .io_out(io_out), .io_oe_n(io_oe_n),
    .osc_driver_en(osc_driver_en), .core_reset(core_reset));

// *** testbench/tb_top.sv ***
// Self-checking bench for the sleep, wake and reset-cause block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import swr_pkg::*;
    localparam int WDT_C = 200;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic ext_n = 1'b1;
    logic [2:0] pins = 3'h0;
    logic [IO_W-1:0] c_out = 6'h00;
    logic [IO_W-1:0] c_oe_n = 6'h3f;
    logic [31:0] prdata, rd;
    logic pready, pslverr, ext_o, ext_oe_n, osc_en, core_reset, irq, er;
    logic [IO_W-1:0] io_out, io_oe_n;
    logic [11:0] held;
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;
    always #12.5 pclk = ~pclk;
    swr_sleep_wake #(.WDT_CYC(WDT_C), .DRT_POR_CYC(20), .DRT_RST_CYC(10)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_reset_pin_n_i(ext_n), .ext_reset_pin_o(ext_o),
        .ext_reset_pin_oe_n(ext_oe_n), .port_pin0(pins[0]), .port_pin1(pins[1]),
        .port_pin3(pins[2]), .core_io_out(c_out), .core_io_oe_n(c_oe_n),
        .io_out(io_out), .io_oe_n(io_oe_n), .osc_driver_en(osc_en),
        .core_reset(core_reset), .irq(irq));
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t %s got %h want %h", $time, m, got, exp);
        end
    endtask : chk
    // Every transfer ends with one idle edge so no strobe is set twice in a step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge pclk);
            n++;
        end
        // Pready set at the first access edge is seen one edge later
        chk(n, 1, "answer late");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string m);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, m);
    endtask : rdchk
    task automatic wait_rst(input logic lvl, input int lim);
        int n;
        n = 0;
        while (core_reset !== lvl && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, core_reset}, {31'h0, lvl}, "core reset");
    endtask : wait_rst
    task automatic cycle(input int lim);
        wait_rst(1'b1, lim);
        wait_rst(1'b0, 40);
    endtask : cycle
    task automatic pulse;
        ext_n <= 1'b0;
        repeat (2) @(posedge pclk);
        ext_n <= 1'b1;
        @(posedge pclk);
    endtask : pulse
    function automatic logic [31:0] st(input logic pw, input logic tm, input logic dn);
        st = 32'h0;
        st[POS_PIN_WAKE] = pw;
        st[POS_TIMEOUT_N] = tm;
        st[POS_POWERDOWN_N] = dn;
    endfunction : st
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            chk(0, 1, "timeout");
            report_and_stop();
        end
    end
    initial begin
        rd = $urandom(74);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        wait_rst(1'b0, 60);
        rdchk(OFF_STATUS, st(1'b0, 1'b1, 1'b1), "status");
        rdchk(OFF_CFG, 32'h5, "cfg");
        chk({30'h0, ext_o, ext_oe_n}, 32'h3, "pin drive");
        apb(1'b0, 8'h1c, 32'h0);
        chk({31'h0, er}, 32'h1, "unmapped err");
        chk(rd, 32'h0, "unmapped data");
        wr_cfg: apb(1'b1, OFF_CFG, 32'h1);
        cycle(WDT_C + 20);
        rdchk(OFF_STATUS, st(1'b0, 1'b0, 1'b1), "wdt run");
        apb(1'b1, OFF_CFG, 32'h2);
        $display("reset and watchdog tests done");
        for (int i = 0; i < 3; i++) begin
            c_out <= 6'($urandom);
            c_oe_n <= 6'($urandom);
            rdchk(OFF_PORT, {29'h0, pins}, "port");
            held = {c_out, c_oe_n};
            apb(1'b1, OFF_CTRL, 32'h1);
            repeat (2) @(posedge pclk);
            chk({31'h0, osc_en}, 32'h0, "osc");
            c_out <= ~c_out;
            c_oe_n <= ~c_oe_n;
            repeat (3) @(posedge pclk);
            chk({io_out, io_oe_n}, held, "io held");
            pins[i] <= ~pins[i];
            cycle(20);
            rdchk(OFF_STATUS, st(1'b1, 1'b1, 1'b0), "pin wake");
            chk({31'h0, irq}, 32'h0, "irq masked");
        end
        apb(1'b1, OFF_IRQ_MASK, 32'h7);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h1, "irq set");
        rdchk(OFF_IRQ_STAT, 32'h3, "irq stat");
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0, "irq clear");
        $display("pin wake tests done");
        rdchk(OFF_PORT, {29'h0, pins}, "port");
        pins[0] <= ~pins[0];
        apb(1'b1, OFF_CTRL, 32'h1);
        cycle(6);
        rdchk(OFF_STATUS, st(1'b1, 1'b1, 1'b0), "stale wake");
        apb(1'b1, OFF_CFG, 32'h6);
        pulse();
        cycle(8);
        rdchk(OFF_STATUS, st(1'b0, 1'b1, 1'b0), "ext run");
        apb(1'b1, OFF_CFG, 32'h5);
        apb(1'b1, OFF_CTRL, 32'h1);
        cycle(WDT_C + 20);
        apb(1'b1, OFF_CFG, 32'h4);
        rdchk(OFF_STATUS, st(1'b0, 1'b0, 1'b0), "wdt wake");
        $display("stale, reset pin and watchdog wake tests done");
        apb(1'b1, OFF_CTRL, 32'h1);
        pins[1] <= ~pins[1];
        repeat (WDT_C + 50) @(posedge pclk);
        chk({30'h0, osc_en, core_reset}, 32'h0, "asleep");
        pulse();
        cycle(8);
        rdchk(OFF_STATUS, st(1'b0, 1'b1, 1'b0), "ext wake");
        apb(1'b1, OFF_CFG, 32'h0);
        pulse();
        repeat (20) @(posedge pclk);
        chk({31'h0, core_reset}, 32'h0, "plain pin");
        rdchk(OFF_STATUS, st(1'b0, 1'b1, 1'b0), "flags kept");
        $display("disabled source tests done");
        report_and_stop();
    end
endmodule : tb_top
